// file: design/ssc_clk_div.sv
// Common clock divider producing a 50 percent duty divided clock
`timescale 1ns/1ps
module ssc_clk_div (
    input wire logic ref_clk,
    input wire logic sys_rst,
    ssc_clk_if.gen div
);
    typedef struct packed {
        logic [ssc_pkg::DivW-1:0] cnt;
        logic clk;
        logic rise;
        logic fall;
    } ssc_div_s;

    ssc_div_s state_ff;
    ssc_div_s nxt_state;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.rise = 1'b0;
        nxt_state.fall = 1'b0;
        if (div.divSetting == '0) begin
            // Idle divider: clock forced low, no rise or fall pulses
            nxt_state.cnt = '0; // R2
            nxt_state.clk = 1'b0; // R2
        end else if (state_ff.cnt >= div.divSetting - 12'h001) begin
            // Each level lasts exactly N cycles
            nxt_state.cnt = '0; // R3
            nxt_state.clk = ~state_ff.clk; // R3
            nxt_state.rise = ~state_ff.clk;
            nxt_state.fall = state_ff.clk;
        end else begin
            nxt_state.cnt = state_ff.cnt + 12'h001; // R1
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign div.divClk = state_ff.clk;
    assign div.divRise = state_ff.rise;
    assign div.divFall = state_ff.fall;

    // Length of the running level; a level in which the setting moved
    // is marked dirty and not measured
    logic [ssc_pkg::DivW-1:0] levelCnt;
    logic [ssc_pkg::DivW-1:0] prevSetting;
    logic levelDirty;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            levelCnt <= '0;
            prevSetting <= '0;
            levelDirty <= 1'b1;
        end else begin
            prevSetting <= div.divSetting;
            if (nxt_state.rise || nxt_state.fall) begin
                levelCnt <= '0;
                levelDirty <= 1'b0;
            end else begin
                levelCnt <= levelCnt + 12'h001;
                if (div.divSetting != prevSetting
                    || div.divSetting == '0) begin
                    levelDirty <= 1'b1;
                end
            end
        end
    end

    level_length_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_ff.rise || state_ff.fall) && !$past(levelDirty)
        && $past(div.divSetting) == $past(prevSetting)
        |-> $past(levelCnt) == $past(div.divSetting) - 12'h001) // R3
        else $error("Divided clock edge at wrong time");
    idle_div_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        div.divSetting == '0 |=> !state_ff.rise && !state_ff.clk) // R2
        else $error("Divider toggles while disabled");
endmodule : ssc_clk_div

// file: design/ssc_clk_if.sv
// Interface carrying the shared divided clock between the two modules
`timescale 1ns/1ps
interface ssc_clk_if;
    logic [ssc_pkg::DivW-1:0] divSetting;
    logic divClk;
    logic divRise;
    logic divFall;
    modport gen (input divSetting, output divClk, divRise, divFall);
    modport use_m (output divSetting, input divClk, divRise, divFall);
endinterface : ssc_clk_if

// file: design/ssc_pkg.sv
// Package of constants and types for the sync serial clock and transmit block
// How it works
// R1 - Divider setting is 12 bits, up to 4095, dividing by up to 8190.
// R2 - Setting zero keeps the divider idle with no divided clock.
// R3 - Each divided clock phase lasts N peripheral clock cycles.
// R4 - One divided clock feeds both transmitter and receiver.
// R5 - Transmit bit clock is receive clock, divided clock or transmit pin.
// R6 - Transmit inversion changes the internal clock, not the pin.
// R7 - Transmit clock pin driven always or only during transfer.
// R8 - Software avoids external transmit clock with continuous output mode.
// R9 - Receive bit clock is transmit clock, divided clock or receive pin.
// R10 - Receive inversion inverts the internally used receive clock.
// R11 - Receive inversion leaves the driven receive clock pin unchanged.
// R12 - Receive clock pin driven always or only during transfer.
// R13 - Software avoids external receive clock with continuous output mode.
// R14 - External receive clock at most half or third of peripheral clock.
// R15 - External transmit clock at most sixth or half of peripheral clock.
// R16 - Transmitter and receiver run independently, may share clock or start.
// R17 - Each transmit frame begins on a start event.
// R18 - Holding register words move into the transmit shift register.
// R19 - Transmit all-empty flag set when holding and shift both empty.
// R20 - Transmit holding-free flag set when holding word moves to shifter.
// R21 - Software disables the controller before gating its clock.
// R22 - Each side can drive its generated clock onto its clock pin.
// R23 - Pin inputs are synchronised and edge-detected before use.
// R24 - Full receive shifter copies to holding, sets ready, or overrun.
package ssc_pkg;
    localparam int DivW = 12;
    localparam int DataW = 32;
    localparam int BitCntW = 5;
    // Register offsets
    localparam logic [3:0] OffDiv = 4'h0;
    localparam logic [3:0] OffTxMode = 4'h1;
    localparam logic [3:0] OffRxMode = 4'h2;
    localparam logic [3:0] OffFrame = 4'h3;
    localparam logic [3:0] OffTxHold = 4'h4;
    localparam logic [3:0] OffRxHold = 4'h5;
    localparam logic [3:0] OffStatus = 4'h6;
    localparam logic [3:0] OffCtrl = 4'h7;
    // Clock source codes
    localparam logic [1:0] CksDiv = 2'h0;
    localparam logic [1:0] CksOther = 2'h1;
    localparam logic [1:0] CksPin = 2'h2;
    // Clock output mode codes
    localparam logic [2:0] CkoNone = 3'h0;
    localparam logic [2:0] CkoCont = 3'h1;
    localparam logic [2:0] CkoXfer = 3'h2;
    // Mode register field positions
    localparam int CksLsb = 0;
    localparam int CkoLsb = 2;
    localparam int CkiBit = 5;
    localparam int StartBit = 8;
    // Frame register: data length minus one, msb-first
    localparam int LenLsb = 0;
    localparam int MsbfBit = 7;
    // Status bit positions
    localparam int StTxReady = 0;
    localparam int StTxEmpty = 1;
    localparam int StRxReady = 4;
    localparam int StOvrun = 5;
    // Control bits
    localparam int CtlTxEn = 0;
    localparam int CtlRxEn = 1;
    localparam logic [DivW-1:0] DivReset = 12'h000;
    localparam logic [15:0] ModeReset = 16'h0000;
    localparam logic [7:0] FrameReset = 8'h1F;

    typedef struct packed {
        logic cnt;
        logic phase;
    } ssc_dummy_s;
endpackage : ssc_pkg

// file: design/ssc_top.sv
// Sync serial controller: clock selection, transmit path, receive capture
`timescale 1ns/1ps
module ssc_top (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    input wire logic txClkIn,
    output logic txClkOut,
    output logic txClkOe,
    output logic txData,
    input wire logic rxClkIn,
    output logic rxClkOut,
    output logic rxClkOe,
    input wire logic rxData,
    input wire logic txFrameSyncIn
);
    typedef struct packed {
        logic [15:0] txMode;
        logic [15:0] rxMode;
        logic [7:0] frame;
        logic [1:0] ctl;
        logic [31:0] txHold;
        logic txHoldFull;
        logic [31:0] txShift;
        logic [ssc_pkg::BitCntW-1:0] txBits;
        logic txBusy;
        logic txReady;
        logic txDataOut;
        logic txFirst;
        logic [31:0] rxShift;
        logic [ssc_pkg::BitCntW-1:0] rxBits;
        logic [31:0] rxHold;
        logic rxReady;
        logic rxOvrun;
        logic [2:0] txPinSync;
        logic [2:0] rxPinSync;
        logic [2:0] fsSync;
        logic txPinLvl;
        logic rxPinLvl;
        logic fsLvl;
        logic [2:0] rxDataSync;
        logic rxDataLvl;
        logic txClkPrev;
        logic rxClkPrev;
        logic [31:0] rdata;
    } ssc_top_s;

    ssc_top_s state_ff;
    ssc_top_s nxt_state;
    ssc_clk_if clkBus ();

    logic [ssc_pkg::DivW-1:0] divSetting_ff;
    logic [ssc_pkg::DivW-1:0] nxt_divSetting;
    assign clkBus.divSetting = divSetting_ff;

    ssc_clk_div uDiv (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .div(clkBus.gen)
    );

    // Pick an uninverted bit clock level from one of three sources
    function automatic logic pickClk(input logic [1:0] sel,
                                     input logic divLvl,
                                     input logic otherLvl,
                                     input logic pinLvl);
        if (sel == ssc_pkg::CksDiv) begin
            return divLvl;
        end else if (sel == ssc_pkg::CksOther) begin
            return otherLvl;
        end else if (sel == ssc_pkg::CksPin) begin
            return pinLvl;
        end else begin
            return 1'b0;
        end
    endfunction : pickClk

    // Pin drive for a given output mode
    function automatic logic pinOe(input logic [2:0] cko,
                                   input logic busy);
        return (cko == ssc_pkg::CkoCont) ||
               (cko == ssc_pkg::CkoXfer && busy);
    endfunction : pinOe

    logic txRawClk;
    logic rxRawClk;
    logic txIntClk;
    logic rxIntClk;
    logic txFall;
    logic rxRise;
    logic txStart;
    logic [ssc_pkg::BitCntW-1:0] txLen;
    logic [ssc_pkg::BitCntW-1:0] rxLen;
    logic rxOtherLvl;

    // Receive clock may follow transmit clock and vice versa; a loop of
    // both pointing at each other resolves to the divider on receive side.
    assign rxOtherLvl =
        (state_ff.txMode[1:0] == ssc_pkg::CksOther) ? clkBus.divClk :
        pickClk(state_ff.txMode[1:0], clkBus.divClk, 1'b0,
                state_ff.txPinLvl);
    assign rxRawClk = pickClk(state_ff.rxMode[1:0], clkBus.divClk,
                              rxOtherLvl, state_ff.rxPinLvl); // R9 R4
    assign txRawClk = pickClk(state_ff.txMode[1:0], clkBus.divClk,
                              rxRawClk, state_ff.txPinLvl); // R5 R4 R16
    assign txIntClk = txRawClk ^ state_ff.txMode[ssc_pkg::CkiBit]; // R6
    assign rxIntClk = rxRawClk ^ state_ff.rxMode[ssc_pkg::CkiBit]; // R10
    assign txFall = state_ff.txClkPrev & ~txIntClk;
    assign rxRise = ~state_ff.rxClkPrev & rxIntClk;
    assign txLen = state_ff.frame[ssc_pkg::BitCntW-1:0];
    assign rxLen = state_ff.frame[ssc_pkg::BitCntW-1:0];
    // Start: continuous, or on frame sync high level when selected
    assign txStart = state_ff.txHoldFull && state_ff.ctl[ssc_pkg::CtlTxEn]
        && (!state_ff.txMode[ssc_pkg::StartBit] || state_ff.fsLvl); // R17

    always_comb begin
        nxt_state = state_ff;
        nxt_divSetting = divSetting_ff;
        nxt_state.rdata = '0;
        // Three-stage sync, level accepted once stages two and three agree
        nxt_state.txPinSync = {state_ff.txPinSync[1:0], txClkIn}; // R23
        nxt_state.rxPinSync = {state_ff.rxPinSync[1:0], rxClkIn}; // R23
        nxt_state.fsSync = {state_ff.fsSync[1:0], txFrameSyncIn}; // R23
        nxt_state.rxDataSync = {state_ff.rxDataSync[1:0], rxData}; // R23
        if (state_ff.txPinSync[2] == state_ff.txPinSync[1]) begin
            nxt_state.txPinLvl = state_ff.txPinSync[2];
        end
        if (state_ff.rxPinSync[2] == state_ff.rxPinSync[1]) begin
            nxt_state.rxPinLvl = state_ff.rxPinSync[2];
        end
        if (state_ff.fsSync[2] == state_ff.fsSync[1]) begin
            nxt_state.fsLvl = state_ff.fsSync[2];
        end
        if (state_ff.rxDataSync[2] == state_ff.rxDataSync[1]) begin
            nxt_state.rxDataLvl = state_ff.rxDataSync[2];
        end
        nxt_state.txClkPrev = txIntClk;
        nxt_state.rxClkPrev = rxIntClk;

        // Transmit shifter, bits change on falling internal clock
        if (state_ff.txBusy && txFall) begin
            if (state_ff.txFirst) begin
                // First edge only presents the leading bit, so no pin
                // rise can catch a word that was loaded mid-level
                nxt_state.txFirst = 1'b0;
            end else if (state_ff.txBits == txLen) begin
                nxt_state.txBusy = 1'b0;
            end else begin
                nxt_state.txBits = state_ff.txBits + 5'h01;
                if (state_ff.frame[ssc_pkg::MsbfBit]) begin
                    nxt_state.txShift = {state_ff.txShift[30:0], 1'b0};
                end else begin
                    nxt_state.txShift = {1'b0, state_ff.txShift[31:1]};
                end
            end
        end
        nxt_state.txDataOut = state_ff.frame[ssc_pkg::MsbfBit] ?
            nxt_state.txShift[txLen] : nxt_state.txShift[0];
        if (!nxt_state.txBusy && txStart) begin
            nxt_state.txShift = state_ff.txHold; // R18
            nxt_state.txBits = '0;
            nxt_state.txBusy = 1'b1;
            nxt_state.txFirst = 1'b1;
            nxt_state.txHoldFull = 1'b0;
            nxt_state.txReady = 1'b1; // R20
        end

        // Receive shifter samples on rising internal clock
        if (state_ff.ctl[ssc_pkg::CtlRxEn] && rxRise) begin
            nxt_state.rxShift = state_ff.frame[ssc_pkg::MsbfBit] ?
                {state_ff.rxShift[30:0], state_ff.rxDataLvl} :
                {state_ff.rxDataLvl, state_ff.rxShift[31:1]};
            if (state_ff.rxBits == rxLen) begin
                nxt_state.rxBits = '0;
                nxt_state.rxHold = nxt_state.rxShift; // R24
                nxt_state.rxReady = 1'b1; // R24
                if (state_ff.rxReady) begin
                    nxt_state.rxOvrun = 1'b1; // R24
                end
            end else begin
                nxt_state.rxBits = state_ff.rxBits + 5'h01;
            end
        end

        if (regWr) begin
            if (regAddr == ssc_pkg::OffDiv) begin
                nxt_divSetting = regWdata[ssc_pkg::DivW-1:0]; // R1
            end else if (regAddr == ssc_pkg::OffTxMode) begin
                nxt_state.txMode = regWdata[15:0];
            end else if (regAddr == ssc_pkg::OffRxMode) begin
                nxt_state.rxMode = regWdata[15:0];
            end else if (regAddr == ssc_pkg::OffFrame) begin
                nxt_state.frame = regWdata[7:0];
            end else if (regAddr == ssc_pkg::OffTxHold) begin
                // A word loaded this cycle is fresh; transfer waits a cycle
                nxt_state.txHold = regWdata;
                nxt_state.txHoldFull = 1'b1;
                nxt_state.txReady = 1'b0;
            end else if (regAddr == ssc_pkg::OffCtrl) begin
                nxt_state.ctl = regWdata[1:0];
            end
        end
        if (regRd) begin
            if (regAddr == ssc_pkg::OffDiv) begin
                nxt_state.rdata = {20'h0_0000, divSetting_ff};
            end else if (regAddr == ssc_pkg::OffTxMode) begin
                nxt_state.rdata = {16'h0000, state_ff.txMode};
            end else if (regAddr == ssc_pkg::OffRxMode) begin
                nxt_state.rdata = {16'h0000, state_ff.rxMode};
            end else if (regAddr == ssc_pkg::OffFrame) begin
                nxt_state.rdata = {24'h00_0000, state_ff.frame};
            end else if (regAddr == ssc_pkg::OffRxHold) begin
                nxt_state.rdata = state_ff.rxHold;
                // A word landing now keeps the ready flag set
                if (!(nxt_state.rxReady && !state_ff.rxReady)
                    && !(rxRise && state_ff.rxBits == rxLen
                         && state_ff.ctl[ssc_pkg::CtlRxEn])) begin
                    nxt_state.rxReady = 1'b0;
                end
            end else if (regAddr == ssc_pkg::OffStatus) begin
                nxt_state.rdata[ssc_pkg::StTxReady] = state_ff.txReady;
                nxt_state.rdata[ssc_pkg::StTxEmpty] =
                    !state_ff.txHoldFull && !state_ff.txBusy; // R19
                nxt_state.rdata[ssc_pkg::StRxReady] = state_ff.rxReady;
                nxt_state.rdata[ssc_pkg::StOvrun] = state_ff.rxOvrun;
                if (!(rxRise && state_ff.rxBits == rxLen
                      && state_ff.rxReady)) begin
                    nxt_state.rxOvrun = 1'b0;
                end
            end else if (regAddr == ssc_pkg::OffCtrl) begin
                nxt_state.rdata = {30'h0000_0000, state_ff.ctl};
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= '0;
            state_ff.txMode <= ssc_pkg::ModeReset;
            state_ff.rxMode <= ssc_pkg::ModeReset;
            state_ff.frame <= ssc_pkg::FrameReset;
            state_ff.txReady <= 1'b1;
            divSetting_ff <= ssc_pkg::DivReset;
        end else begin
            state_ff <= nxt_state;
            divSetting_ff <= nxt_divSetting;
        end
    end

    // Pins carry the uninverted clock; internal inversion never reaches them
    assign txClkOut = txRawClk; // R22 R6
    assign rxClkOut = rxRawClk; // R22 R11
    assign txClkOe = pinOe(state_ff.txMode[4:2],
                           state_ff.txBusy && !state_ff.txFirst); // R7
    assign rxClkOe = pinOe(state_ff.rxMode[4:2],
                           state_ff.ctl[ssc_pkg::CtlRxEn]); // R12
    assign txData = state_ff.txDataOut;
    assign regRdata = state_ff.rdata;

    sequence holdLoadS;
        !state_ff.txBusy && txStart;
    endsequence
    tx_load_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        holdLoadS |=> state_ff.txBusy && state_ff.txReady
        && !state_ff.txHoldFull) // R18
        else $error("Holding word not moved to shifter");
    tx_ready_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        holdLoadS and !regWr |=> state_ff.txReady) // R20
        else $error("Ready flag not set on transfer");
    tx_pin_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        txClkOut == txRawClk && txIntClk ==
        (txClkOut ^ state_ff.txMode[ssc_pkg::CkiBit])) // R6
        else $error("Transmit pin clock affected by inversion");
    rx_inv_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        rxIntClk != rxClkOut |-> state_ff.rxMode[ssc_pkg::CkiBit]) // R10
        else $error("Receive clock inverted without the bit");
    rx_pin_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        rxClkOut == rxRawClk) // R11
        else $error("Receive pin clock altered");
    tx_oe_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_ff.txMode[4:2] == ssc_pkg::CkoCont |-> txClkOe) // R7
        else $error("Continuous transmit clock not driven");
    rx_oe_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_ff.rxMode[4:2] == ssc_pkg::CkoNone |-> !rxClkOe) // R12
        else $error("Receive clock driven when off");
    div_src_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_ff.txMode[1:0] == ssc_pkg::CksDiv |->
        txRawClk == clkBus.divClk) // R5
        else $error("Transmit clock not from divider");
    rx_src_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_ff.rxMode[1:0] == ssc_pkg::CksPin |->
        rxRawClk == state_ff.rxPinLvl) // R9
        else $error("Receive clock not from pin");
    rx_over_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_ff.ctl[ssc_pkg::CtlRxEn] && rxRise &&
        state_ff.rxBits == rxLen && state_ff.rxReady |=>
        state_ff.rxOvrun && state_ff.rxReady) // R24
        else $error("Overrun not flagged");
endmodule : ssc_top

// file: verif/ssc_codec_model.sv
// Behavioural far-side codec: external bit clock, receive data, capture
`timescale 1ns/1ps
module ssc_codec_model (
    input wire logic clkRun,
    input wire logic txClkOut,
    input wire logic txClkOe,
    input wire logic txData,
    output logic extClk,
    output logic rxData,
    output logic frameSync,
    output logic [31:0] capWord,
    output int capCount
);
    ////////////////////////////////////////////////////////////////////////
    // A 32 ns bit clock is slower than a sixth of the peripheral clock,
    // so it stays legal whichever way the frame sync points
    initial begin
        extClk = 1'b0;
        #3;
        forever begin
            #16;
            extClk = clkRun ? ~extClk : 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Data held high keeps the received word independent of frame phase
    assign rxData = 1'b1;
    assign frameSync = 1'b0;
    initial capWord = 32'h0000_0000;
    initial capCount = 0;
    // Rising pin edge: the transmitter moves data on the falling one
    always @(posedge txClkOut) begin
        if (txClkOe) begin
            capWord <= {capWord[30:0], txData};
            capCount <= capCount + 1;
        end
    end
endmodule : ssc_codec_model

// file: verif/testbench.sv
// Self-checking bench for the sync serial clock and transmit block
`timescale 1ns/1ps
module testbench;
    logic ref_clk, sys_rst, regWr, regRd, rxData, extClk, frameSync;
    logic txClkOut, txClkOe, txData, rxClkOut, rxClkOe, clkRun, prevTx;
    logic [3:0] regAddr;
    logic [31:0] regWdata, regRdata, rd, capWord;
    int capCount, fail_count, tests_run, txRises, rxRises, extRises;
    int hiRun, loRun, run, c0, r0, e0, d;
    ssc_top u_ssc_top (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .txClkIn(extClk),
        .txClkOut(txClkOut), .txClkOe(txClkOe), .txData(txData),
        .rxClkIn(extClk), .rxClkOut(rxClkOut), .rxClkOe(rxClkOe),
        .rxData(rxData), .txFrameSyncIn(frameSync));
    ssc_codec_model u_ssc_codec_model (.clkRun(clkRun),
        .txClkOut(txClkOut), .txClkOe(txClkOe), .txData(txData),
        .extClk(extClk), .rxData(rxData), .frameSync(frameSync),
        .capWord(capWord), .capCount(capCount));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge txClkOut) txRises++;
    always @(posedge rxClkOut) rxRises++;
    always @(posedge extClk) extRises++;
    // Length of the last high and low phase of the transmit clock pin
    always @(posedge ref_clk) begin
        prevTx <= txClkOut;
        if (txClkOut === prevTx) begin
            run <= run + 1;
        end else begin
            if (prevTx) hiRun <= run;
            else loRun <= run;
            run <= 1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= v;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask : reg_write
    // Read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [3:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1 v = regRdata;
    endtask : reg_read
    task automatic wait_flag(input int pos);
        for (int i = 0; i < 100; i++) begin
            reg_read(ssc_pkg::OffStatus, rd);
            if (rd[pos] === 1'b1) break;
        end
    endtask : wait_flag
    function automatic logic [31:0] mode(input logic [1:0] src,
                                         input logic [2:0] cko,
                                         input logic inv);
        logic [31:0] m;
        m = 32'h0000_0000;
        m[ssc_pkg::CksLsb +: 2] = src;
        m[ssc_pkg::CkoLsb +: 3] = cko;
        m[ssc_pkg::CkiBit] = inv;
        return m;
    endfunction : mode
    task automatic modes(input logic [31:0] tx, input logic [31:0] rx);
        reg_write(ssc_pkg::OffTxMode, tx);
        reg_write(ssc_pkg::OffRxMode, rx);
    endtask : modes
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        give_verdict();
    end
    initial begin
        sys_rst = 1'b1;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 4'h0;
        regWdata = 32'h0000_0000;
        clkRun = 1'b0;
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        reg_read(ssc_pkg::OffStatus, rd);
        chk("tx empty", rd & 32'h0000_0002, 32'h0000_0002);
        reg_read(4'h9, rd);
        chk("unmapped", rd, 32'h0000_0000);
        reg_write(ssc_pkg::OffDiv, 32'hFFFF_FFFF);
        reg_read(ssc_pkg::OffDiv, rd);
        chk("divider max", rd, 32'h0000_0FFF);
        reg_write(ssc_pkg::OffDiv, 32'h0000_0000);
        modes(mode(ssc_pkg::CksDiv, ssc_pkg::CkoCont, 1'b0), 32'h0000_0000);
        c0 = txRises;
        repeat (40) @(posedge ref_clk);
        chk("idle divider", 32'(txRises - c0), 32'h0000_0000);
        // Odd settings must still split the period evenly
        for (int n = 1; n <= 3; n += 2) begin
            reg_write(ssc_pkg::OffDiv, 32'(n));
            modes(mode(ssc_pkg::CksDiv, ssc_pkg::CkoCont, 1'b1),
                  mode(ssc_pkg::CksDiv, ssc_pkg::CkoCont, 1'b0));
            repeat (20) @(posedge ref_clk);
            #1;
            chk("high phase", 32'(hiRun), 32'(n));
            chk("low phase", 32'(loRun), 32'(n));
            chk("pins equal", {31'h0, txClkOut ^ rxClkOut}, 0);
            chk("oe cont", {30'h0, txClkOe, rxClkOe}, 32'h3);
        end
        modes(mode(ssc_pkg::CksDiv, ssc_pkg::CkoNone, 1'b0),
              mode(ssc_pkg::CksDiv, ssc_pkg::CkoNone, 1'b1));
        #1 chk("oe none", {30'h0, txClkOe, rxClkOe}, 32'h0);
        // External pin clock taken with transfer-only output; receive side relays it continuously
        clkRun <= 1'b1;
        modes(mode(ssc_pkg::CksPin, ssc_pkg::CkoXfer, 1'b0),
              mode(ssc_pkg::CksOther, ssc_pkg::CkoCont, 1'b0));
        repeat (20) @(posedge ref_clk);
        e0 = extRises;
        r0 = rxRises;
        repeat (200) @(posedge ref_clk);
        d = (rxRises - r0) - (extRises - e0);
        chk("pin follow", {31'h0, d >= -1 && d <= 1}, 1);
        chk("tx oe idle", {31'h0, txClkOe}, 0);
        clkRun <= 1'b0;
        reg_write(ssc_pkg::OffDiv, 32'h0000_0002);
        modes(mode(ssc_pkg::CksDiv, ssc_pkg::CkoXfer, 1'b0), 32'h0000_0000);
        reg_write(ssc_pkg::OffFrame, 32'h0000_0087);
        reg_write(ssc_pkg::OffCtrl, 32'h0000_0001);
        c0 = capCount;
        reg_write(ssc_pkg::OffTxHold, 32'h0000_00A5);
        reg_write(ssc_pkg::OffTxHold, 32'h0000_003C);
        reg_read(ssc_pkg::OffStatus, rd);
        chk("both full", rd & 32'h0000_0003, 32'h0000_0000);
        wait_flag(ssc_pkg::StTxReady);
        chk("holding free", rd & 32'h0000_0003, 32'h0000_0001);
        wait_flag(ssc_pkg::StTxEmpty);
        chk("all empty", rd & 32'h0000_0003, 32'h0000_0003);
        repeat (8) @(posedge ref_clk);
        chk("bit count", 32'(capCount - c0), 32'h0000_0010);
        chk("tx bits", capWord & 32'h0000_FFFF, 32'h0000_A53C);
        chk("oe after", {31'h0, txClkOe}, 0);
        // Start on frame sync high: a sync held low keeps the word waiting
        reg_write(ssc_pkg::OffTxMode, mode(ssc_pkg::CksDiv, ssc_pkg::CkoXfer,
                  1'b0) | (32'h0000_0001 << ssc_pkg::StartBit));
        reg_write(ssc_pkg::OffTxHold, 32'h0000_00C3);
        repeat (40) @(posedge ref_clk);
        reg_read(ssc_pkg::OffStatus, rd);
        chk("sync wait", rd & 32'h0000_0003, 32'h0000_0000);
        reg_write(ssc_pkg::OffRxMode,
                  mode(ssc_pkg::CksDiv, ssc_pkg::CkoXfer, 1'b0));
        reg_write(ssc_pkg::OffCtrl, 32'h0000_0003);
        wait_flag(ssc_pkg::StRxReady);
        chk("rx oe", {31'h0, rxClkOe}, 1);
        reg_read(ssc_pkg::OffRxHold, rd);
        chk("rx word", rd, 32'h0000_00FF);
        repeat (80) @(posedge ref_clk);
        reg_read(ssc_pkg::OffStatus, rd);
        chk("overrun", rd & 32'h0000_0030, 32'h0000_0030);
        // Disable before stopping, so nothing is left mid-frame
        reg_write(ssc_pkg::OffCtrl, 32'h0000_0000);
        give_verdict();
    end
endmodule : testbench
